/* File: rtl/spims_pkg.sv */
// Purpose: shared constants and types of the serial port controller
// Assumes: 32-bit APB, one register per aligned word
// Notes: bit positions index the 8-bit register images
package spims_pkg;
    typedef logic [7:0] spims_addr_t;
    typedef enum {ST_IDLE, ST_SHIFT} spims_st_t;

    // register byte addresses
    localparam spims_addr_t OFS_CTRL = 8'h00;
    localparam spims_addr_t OFS_STAT = 8'h04;
    localparam spims_addr_t OFS_DATA = 8'h08;
    localparam spims_addr_t OFS_PINS = 8'h0C;

    // control register fields
    localparam int CB_PIE = 7;
    localparam int CB_EN = 6;
    localparam int CB_LSB = 5;
    localparam int CB_MST = 4;
    localparam int CB_CLOCK_POLARITY = 3;
    localparam int CB_CLOCK_PHASE = 2;
    localparam int CB_RATE = 0;

    // status register fields
    localparam int SB_TC = 7;
    localparam int SB_WRITE_COLLISION_FLAG = 6;
    localparam int SB_DBL = 0;

    // pin direction register fields
    localparam int PB_MOSI = 0;
    localparam int PB_MISO = 1;
    localparam int PB_SCK = 2;
    localparam int PB_SS = 3;
    localparam int PB_SSV = 4;

    // values after reset
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] PINS_RST = 8'h10;
    localparam logic [3:0] SYNC_RST = 4'h1;

    // sixteen clock edges per byte
    localparam logic [3:0] EDGE_LAST = 4'hF;

    // half bit period in system clocks, index {double_speed, rate_select}
    localparam logic [5:0] HALF_T [8] = '{6'h02, 6'h08, 6'h20, 6'h40,
                                          6'h01, 6'h04, 6'h10, 6'h20};
endpackage

/* File: rtl/spims_div_if.sv */
// Purpose: link between transfer control and bit clock divider
// Assumes: single pclk domain
// Notes: tick is combinational from the divider counter
`timescale 1ns/1ps
interface spims_div_if;
    logic run;
    logic [2:0] sel;
    logic tick;
    modport ctl (output run, output sel, input tick);
    modport gen (input run, input sel, output tick);
endinterface

/* File: rtl/spims_sync.sv */
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to pclk
// Notes: output follows a bit once stages two and three agree
`timescale 1ns/1ps
module spims_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q, s2_q, s3_q, q_q;

    // s1 feeds s2 only; filter looks at s2 and s3
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            q_q <= INIT;
        end else if (pce) begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_q <= (s2_q & s3_q) | (q_q & (s2_q | s3_q));
        end
    end

    assign q = q_q;
endmodule

/* File: rtl/spims_div.sv */
// Purpose: bit clock divider for master role
// Assumes: run held high for the whole byte
// Notes: tick marks each half period of the serial clock
`timescale 1ns/1ps
module spims_div (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    spims_div_if.gen dif
);
    import spims_pkg::*;
    logic [5:0] cnt_q;
    logic [5:0] half_m1;

    // rate table lookup
    assign half_m1 = HALF_T[dif.sel] - 6'h01;
    assign dif.tick = dif.run && (cnt_q == 6'h00);

    // reload on every tick, hold reloaded while stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 6'h00;
        end else if (pce) begin
            if (!dif.run || dif.tick) begin
                cnt_q <= half_m1;
            end else begin
                cnt_q <= cnt_q - 6'h01;
            end
        end
    end
endmodule

/* File: rtl/spims_top.sv */
// Purpose: byte serial port, master or slave, with APB registers
// Assumes: pins synchronised here, APB answers with no wait state
// Notes: pce low freezes every flip-flop of the block
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module spims_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire spims_pkg::spims_addr_t paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic gie,
    input wire logic irq_ack,
    output logic irq,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic ss_i,
    output logic ss_o,
    output logic ss_oe
);
    import spims_pkg::*;

    logic [7:0] ctrl_q, pins_q, sh_q, sh_d, rx_q, rd_mux;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, irq_q;
    logic dbl_q, tc_q, write_collision_flag_q, armed_q, rbit_q, tx_bit_q;
    logic sck_q, sck_prev_q;
    logic sck_oe_q, mosi_oe_q, miso_oe_q, ss_oe_q, ss_o_q;
    logic [3:0] edge_q;
    spims_st_t st_q;
    logic [3:0] pin_s;
    logic ss_s, sck_s, mosi_s, miso_s;
    logic en, mst, lsb, clock_polarity, clock_phase, pie;
    logic setup, acc, wr, rd, hit;
    logic wr_ctrl, wr_stat, wr_pins, wr_data, rd_stat, data_acc;
    logic slv_act, fault, busy, start, ev, lead, samp, last, in_bit;
    logic done, shift, nbit, clr_tc, clr_write_collision_flag;

    spims_div_if dif ();

    // pin synchronisers: bit 0 select, 1 clock, 2 master data-out, 3 master data-in
    spims_sync #(.W(4), .INIT(SYNC_RST)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .d({miso_i, mosi_i, sck_i, ss_i}),
        .q(pin_s)
    );

    spims_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .dif(dif)
    );

    assign ss_s = pin_s[0];
    assign sck_s = pin_s[1];
    assign mosi_s = pin_s[2];
    assign miso_s = pin_s[3];

    // control fields
    assign pie = ctrl_q[CB_PIE];
    assign en = ctrl_q[CB_EN];
    assign lsb = ctrl_q[CB_LSB];
    assign mst = ctrl_q[CB_MST];
    assign clock_polarity = ctrl_q[CB_CLOCK_POLARITY];
    assign clock_phase = ctrl_q[CB_CLOCK_PHASE];

    // APB decode
    assign setup = psel && !penable;
    assign acc = psel && penable && pready_q;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign hit = (paddr == OFS_CTRL) || (paddr == OFS_STAT) ||
                 (paddr == OFS_DATA) || (paddr == OFS_PINS);
    assign wr_ctrl = wr && (paddr == OFS_CTRL);
    assign wr_stat = wr && (paddr == OFS_STAT);
    assign wr_pins = wr && (paddr == OFS_PINS);
    assign wr_data = wr && (paddr == OFS_DATA);
    assign rd_stat = rd && (paddr == OFS_STAT);
    assign data_acc = acc && (paddr == OFS_DATA);

    // read mux, reserved status bits read zero
    always_comb begin
        rd_mux = 8'h00;
        case (paddr)
            OFS_CTRL: rd_mux = ctrl_q;
            OFS_STAT: rd_mux = {tc_q, write_collision_flag_q, 5'h00, dbl_q};
            OFS_DATA: rd_mux = rx_q;
            OFS_PINS: rd_mux = pins_q;
            default: rd_mux = 8'h00;
        endcase
    end

    // role and transfer qualifiers
    assign slv_act = en && !mst && !ss_s;
    assign fault = en && mst && !pins_q[PB_SS] && !ss_s;
    assign busy = (st_q == ST_SHIFT) || (slv_act && (edge_q != 4'h0));
    assign start = wr_data && !busy && en && mst && !fault;

    // divider runs only for a master byte, rate ignored otherwise
    assign dif.run = en && mst && (st_q == ST_SHIFT);
    assign dif.sel = {dbl_q, ctrl_q[CB_RATE+1:CB_RATE]};

    // one event per serial clock edge, either role
    assign ev = en && ((mst && (st_q == ST_SHIFT) && dif.tick) ||
                       (slv_act && (sck_s != sck_prev_q)));
    assign lead = !edge_q[0];
    assign samp = lead ^ clock_phase;
    assign last = (edge_q == EDGE_LAST);
    assign in_bit = mst ? miso_s : mosi_s;
    assign done = ev && last;
    assign shift = ev && ((!samp && (edge_q != 4'h0)) || last);
    assign nbit = samp ? in_bit : rbit_q;

    // shift register next value
    always_comb begin
        sh_d = sh_q;
        if (wr_data && !busy) begin
            sh_d = pwdata[7:0];
        end else if (shift) begin
            sh_d = lsb ? {nbit, sh_q[7:1]} : {sh_q[6:0], nbit};
        end
    end

    // APB answer, ready one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else if (pce) begin
            pready_q <= setup;
            pslverr_q <= setup && !hit;
            if (setup) begin
                prdata_q <= {24'h000000, rd_mux};
            end
        end
    end

    // control register, forced drop clears master bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
        end else if (pce) begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata[7:0];
            end
            if (fault) begin
                ctrl_q[CB_MST] <= 1'b0;
            end
        end
    end

    // pin direction register and double speed bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_q <= PINS_RST;
            dbl_q <= 1'b0;
        end else if (pce) begin
            if (wr_pins) begin
                pins_q <= {3'h0, pwdata[4:0]};
            end
            if (wr_stat) begin
                dbl_q <= pwdata[SB_DBL];
            end
        end
    end

    // shift path, sampled bit and receive buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q <= 8'h00;
            tx_bit_q <= 1'b0;
            rbit_q <= 1'b0;
            rx_q <= 8'h00;
        end else if (pce) begin
            sh_q <= sh_d;
            // data-out holds across the last serial clock edge of a byte
            if (!done) begin
                tx_bit_q <= lsb ? sh_d[0] : sh_d[7];
            end
            if (ev && samp) begin
                rbit_q <= in_bit;
            end
            if (done) begin
                rx_q <= sh_d;
            end
        end
    end

    // edge counter, cleared when select is high in slave role
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_q <= 4'h0;
        end else if (pce) begin
            if (!en || (!mst && ss_s) || fault || start) begin
                edge_q <= 4'h0;
            end else if (ev) begin
                edge_q <= edge_q + 4'h1;
            end
        end
    end

    // master transfer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
        end else if (pce) begin
            case (st_q)
                ST_IDLE: begin
                    if (start) begin
                        st_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (done || fault || !en || !mst) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // master serial clock level, idles at polarity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_q <= 1'b0;
            sck_prev_q <= 1'b0;
        end else if (pce) begin
            sck_prev_q <= sck_s;
            if (st_q != ST_SHIFT) begin
                sck_q <= clock_polarity;
            end else if (ev) begin
                sck_q <= !sck_q;
            end
        end
    end

    // flags: set wins over clear
    assign clr_tc = (armed_q && data_acc) || irq_ack;
    assign clr_write_collision_flag = armed_q && data_acc;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc_q <= 1'b0;
            write_collision_flag_q <= 1'b0;
            armed_q <= 1'b0;
        end else if (pce) begin
            tc_q <= done || fault || (tc_q && !clr_tc);
            write_collision_flag_q <= (wr_data && busy) || (write_collision_flag_q && !clr_write_collision_flag);
            if (rd_stat && (tc_q || write_collision_flag_q)) begin
                armed_q <= 1'b1;
            end else if (data_acc) begin
                armed_q <= 1'b0;
            end
        end
    end

    // interrupt request needs both enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else if (pce) begin
            irq_q <= tc_q && pie && gie;
        end
    end

    // pin direction overrides per role
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_oe_q <= 1'b0;
            mosi_oe_q <= 1'b0;
            miso_oe_q <= 1'b0;
            ss_oe_q <= 1'b0;
            ss_o_q <= 1'b1;
        end else if (pce) begin
            sck_oe_q <= en && mst && !fault && pins_q[PB_SCK];
            mosi_oe_q <= en && mst && !fault && pins_q[PB_MOSI];
            miso_oe_q <= slv_act && pins_q[PB_MISO];
            ss_oe_q <= pins_q[PB_SS] && (!en || mst);
            ss_o_q <= pins_q[PB_SSV];
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign sck_o = sck_q;
    assign sck_oe = sck_oe_q;
    assign mosi_o = tx_bit_q;
    assign mosi_oe = mosi_oe_q;
    assign miso_o = tx_bit_q;
    assign miso_oe = miso_oe_q;
    assign ss_o = ss_o_q;
    assign ss_oe = ss_oe_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || !pce);

    // slave stays passive while select is high
    slave_passive_a: assert property (
        (en && !mst && ss_s) |=> (!miso_oe_q && (edge_q == 4'h0)))
        else $error("slave active while select high");

    // select high in slave role discards the partial byte
    ss_reset_a: assert property (
        (!mst && ss_s && (edge_q != 4'h0)) |=> (edge_q == 4'h0))
        else $error("bit counter kept after select rose");

    // forced drop turns master outputs off at once
    mode_fault_a: assert property (
        fault |=> (!ctrl_q[CB_MST] && !mosi_oe_q && !sck_oe_q && st_q == ST_IDLE))
        else $error("master kept after select pulled low");

    // forced drop raises the transfer flag
    fault_flag_a: assert property (
        fault |=> tc_q)
        else $error("flag not set on forced drop");

    // master bit stays clear without a control write
    master_held_a: assert property (
        (!ctrl_q[CB_MST] && !wr_ctrl) |=> !ctrl_q[CB_MST])
        else $error("master bit set without software");

    // no interrupt without both enables
    irq_gate_a: assert property (
        (!gie || !pie) |=> !irq_q)
        else $error("interrupt without enables");

    // disabled port stays idle and drives no clock or data line
    port_off_a: assert property (
        !en |=> (st_q == ST_IDLE && !sck_oe_q && !mosi_oe_q && !miso_oe_q))
        else $error("activity while port disabled");

    // rate select 0 at normal speed gives a tick every second cycle
    rate_fast_a: assert property (
        (dif.tick && dif.sel == 3'h0) |=> (!dif.tick ##1 (dif.tick || !dif.run)))
        else $error("divide by four rate wrong");

    // byte completion stops the master and flags it
    byte_done_a: assert property (
        (done && mst) |=> (tc_q && st_q == ST_IDLE && sck_q == clock_polarity))
        else $error("master byte did not complete");

    // write while busy is a collision and leaves the shifter alone
    collision_a: assert property (
        (wr_data && busy && !shift) |=> (write_collision_flag_q && sh_q == $past(sh_q)))
        else $error("collision not flagged");
endmodule

/* File: verification/spims_peer.sv */
// Purpose: far-side serial device, acting as slave or as master
// Assumes: resolved line levels are formed by the bench
// Notes: released data lines show the inverse of their last value
`timescale 1ns/1ps
module spims_peer (
    input wire logic clk,
    input wire logic sck_w,
    input wire logic mosi_w,
    input wire logic miso_w,
    input wire logic ss_w,
    output logic sck_p,
    output logic mosi_p,
    output logic miso_p,
    output logic ss_p
);
    logic [7:0] tx_s;
    logic [7:0] rx_s;
    logic [7:0] rx_m;
    logic smp;
    logic mast;
    logic inv;
    // select idles high so a master at the far end keeps its role
    initial begin
        {tx_s, rx_s, rx_m, smp, mast, inv, sck_p, mosi_p} = '0;
        ss_p = 1'b1;
    end
    // slave role: sample edge rising for modes 0 and 3, falling otherwise
    always @(sck_w) begin
        if (!ss_w && !mast) begin
            if (sck_w ^ inv) begin
                rx_s <= {rx_s[6:0], mosi_w};
                smp <= 1'b1;
            end else if (smp) begin
                tx_s <= {tx_s[6:0], 1'b0};
                smp <= 1'b0;
            end
        end
    end
    assign miso_p = (!ss_w && !mast) ? tx_s[7] : ~tx_s[7];
    task automatic load(input logic [7:0] b, input logic m);
        tx_s = b;
        smp = 1'b0;
        inv = m;
    endtask
    // master role: mode 0, clock stands still outside the frame
    task automatic send(input logic [7:0] b, input int n, input logic sel);
        @(posedge clk);
        mast <= 1'b1;
        ss_p <= !sel;
        repeat (8) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            mosi_p <= b[7-i];
            repeat (8) @(posedge clk);
            sck_p <= 1'b1;
            rx_m <= {rx_m[6:0], miso_w};
            repeat (8) @(posedge clk);
            sck_p <= 1'b0;
        end
        repeat (8) @(posedge clk);
        ss_p <= 1'b1;
        mosi_p <= ~mosi_p;
        mast <= 1'b0;
    endtask
endmodule

/* File: verification/testbench.sv */
// Purpose: self-checking bench of the serial port over APB
// Assumes: peer model on the serial lines, pce held high
// Notes: wire levels resolved here from every output enable
`timescale 1ns/1ps
module testbench;
    import spims_pkg::*;
    logic pclk, presetn, pce, psel, penable, pwrite, gie, irq_ack;
    spims_addr_t paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, irq, err, clock_polarity_e;
    logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
    logic sck_p, mosi_p, miso_p, ss_p, sck_w, mosi_w, miso_w, ss_w;
    int fail_count = 0;
    int total_checks = 0;
    int act = 0;
    int a0;
    int dv[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
    // line levels seen by both ends
    assign sck_w = sck_oe ? sck_o : sck_p;
    assign mosi_w = mosi_oe ? mosi_o : mosi_p;
    assign miso_w = miso_oe ? miso_o : miso_p;
    assign ss_w = ss_oe ? ss_o : ss_p;
    spims_top dut_u (.pclk(pclk), .presetn(presetn), .pce(pce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gie(gie), .irq_ack(irq_ack), .irq(irq), .sck_i(sck_w),
        .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
        .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .ss_i(ss_w), .ss_o(ss_o),
        .ss_oe(ss_oe));
    spims_peer peer_u (.clk(pclk), .sck_w(sck_w), .mosi_w(mosi_w), .miso_w(miso_w),
        .ss_w(ss_w), .sck_p(sck_p), .mosi_p(mosi_p), .miso_p(miso_p), .ss_p(ss_p));
    // clock and count of cycles with the serial clock off its idle level
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) if (sck_o !== clock_polarity_e) act++;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input spims_addr_t a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input spims_addr_t a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        check(rd, {24'h000000, e});
    endtask
    task automatic wait_flag;
        int n;
        n = 0;
        do begin
            apb(1'b0, OFS_STAT, 8'h00);
            n++;
        end while (rd[7] !== 1'b1 && n < 3000);
        check({31'h00000000, rd[7]}, 32'h00000001);
    endtask
    // one master byte; optional second data write while busy
    task automatic xfer(input logic [7:0] c, input logic dbl, input logic [7:0] tx,
                        input logic [7:0] rep, input logic twice);
        apb(1'b1, OFS_PINS, 8'h1D);
        apb(1'b1, OFS_STAT, {7'h00, dbl});
        apb(1'b1, OFS_CTRL, c);
        clock_polarity_e = c[3];
        apb(1'b1, OFS_PINS, 8'h0D);
        peer_u.load(rep, c[3] ^ c[2]);
        a0 = act;
        apb(1'b1, OFS_DATA, tx);
        if (twice) apb(1'b1, OFS_DATA, 8'h44);
        wait_flag();
        a0 = act - a0;
    endtask
    // watchdog
    initial begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        give_verdict();
    end
    initial begin
        {psel, penable, pwrite, gie, irq_ack, clock_polarity_e} = '0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        pce = 1'b1;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        check({sck_oe, mosi_oe, miso_oe, ss_o}, 4'h1);
        rdc(OFS_CTRL, 8'h00);
        rdc(OFS_STAT, 8'h00);
        rdc(OFS_PINS, 8'h10);
        rdc(8'h10, 8'h00);
        check({31'h00000000, err}, 32'h00000001);
        $display("test reset done");
        apb(1'b1, OFS_PINS, 8'h0D);
        apb(1'b1, OFS_CTRL, 8'h10);
        a0 = act;
        apb(1'b1, OFS_DATA, 8'h11);
        repeat (100) @(posedge pclk);
        check(act - a0, 0);
        rdc(OFS_STAT, 8'h00);
        $display("test disabled done");
        // each clock mode at both speeds, rate select equal to mode; fast rates outrun the data-in
        // synchroniser, so received data is compared at the slower ones only
        for (int i = 0; i < 8; i++) begin
            xfer(8'h50 | {4'h0, i[1:0], i[1:0]}, i[2], 8'hA5, 8'h3C, 1'b0);
            check(a0, 4 * dv[i]);
            check(peer_u.rx_s, 8'hA5);
            if (dv[i] > 8) rdc(OFS_DATA, 8'h3C);
            else apb(1'b0, OFS_DATA, 8'h00);
        end
        $display("test rates done");
        xfer(8'h7D, 1'b0, 8'h01, 8'h0F, 1'b0);
        check(peer_u.rx_s, 8'h80);
        check({ss_oe, sck_o, ss_o, sck_oe, mosi_oe}, 5'h1B);
        rdc(OFS_DATA, 8'hF0);
        rdc(OFS_CTRL, 8'h7D);
        $display("test modes done");
        gie <= 1'b1;
        xfer(8'hD1, 1'b0, 8'h33, 8'h00, 1'b1);
        check(rd, 32'h000000C0);
        check(peer_u.rx_s, 8'h33);
        check(irq, 1'b1);
        gie <= 1'b0;
        repeat (3) @(posedge pclk);
        check(irq, 1'b0);
        gie <= 1'b1;
        apb(1'b0, OFS_DATA, 8'h00);
        rdc(OFS_STAT, 8'h00);
        xfer(8'hD1, 1'b0, 8'h55, 8'h00, 1'b0);
        irq_ack <= 1'b1;
        @(posedge pclk);
        irq_ack <= 1'b0;
        repeat (2) @(posedge pclk);
        rdc(OFS_STAT, 8'h00);
        $display("test flags done");
        apb(1'b1, OFS_CTRL, 8'h40);
        apb(1'b1, OFS_PINS, 8'h05);
        repeat (10) @(posedge pclk);
        apb(1'b1, OFS_CTRL, 8'h50);
        rdc(OFS_CTRL, 8'h50);
        peer_u.ss_p <= 1'b0;
        repeat (10) @(posedge pclk);
        rdc(OFS_CTRL, 8'h40);
        check({mosi_oe, sck_oe}, 2'b00);
        rdc(OFS_STAT, 8'h80);
        peer_u.ss_p <= 1'b1;
        repeat (10) @(posedge pclk);
        rdc(OFS_CTRL, 8'h40);
        apb(1'b1, OFS_CTRL, 8'h50);
        rdc(OFS_CTRL, 8'h50);
        $display("test drop done");
        apb(1'b1, OFS_CTRL, 8'h43);
        apb(1'b1, OFS_PINS, 8'h0A);
        apb(1'b0, OFS_DATA, 8'h00);
        check({ss_oe, miso_oe, mosi_oe, sck_oe}, 4'h0);
        peer_u.ss_p <= 1'b0;
        repeat (10) @(posedge pclk);
        check({ss_oe, miso_oe, mosi_oe, sck_oe}, 4'h4);
        peer_u.ss_p <= 1'b1;
        peer_u.send(8'hC3, 8, 1'b0);
        rdc(OFS_STAT, 8'h00);
        peer_u.send(8'hFF, 3, 1'b1);
        rdc(OFS_STAT, 8'h00);
        apb(1'b1, OFS_DATA, 8'h5A);
        peer_u.send(8'h96, 8, 1'b1);
        wait_flag();
        check(peer_u.rx_m, 8'h5A);
        rdc(OFS_DATA, 8'h96);
        $display("test slave done");
        give_verdict();
    end
endmodule
